// File: logic/ftbs_access.sv
// Access control, burst counter and array of the flow-through burst SRAM.
`timescale 1ns/1ps
`default_nettype none
module ftbs_access #(
   parameter int ARRAY_AW = ftbs_pkg::ADDR_W
) (
   input  wire logic                        clk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        clock_qualifier_n_i,
   input  wire logic                        chip_select_first_n_i,
   input  wire logic                        chip_select_second_i,
   input  wire logic                        chip_select_third_n_i,
   input  wire logic                        advance_or_load_i,
   input  wire logic                        write_n_i,
   input  wire logic [ftbs_pkg::LANES-1:0]  byte_lane_write_n_i,
   input  wire logic [ftbs_pkg::ADDR_W-1:0] addr_i,
   input  wire logic                        output_enable_n_i,
   input  wire logic                        burst_order_strap_i,
   input  wire logic [ftbs_pkg::DATA_W-1:0] data_i,
   output logic      [ftbs_pkg::DATA_W-1:0] data_o,
   output logic                             data_oe_o,
   output logic                             post_ready_o,
   input  wire logic                        test_clk_i,
   input  wire logic                        test_data_i,
   input  wire logic                        test_mode_i,
   output logic                             test_data_o,
   output logic                             test_data_oe_o
);

   localparam int AW = ftbs_pkg::ADDR_W;
   localparam int DW = ftbs_pkg::DATA_W;
   localparam int LW = ftbs_pkg::LANE_W;
   localparam int NL = ftbs_pkg::LANES;
   localparam int BW = ftbs_pkg::BURST_W;
   localparam int ACCESS_CYC = ftbs_pkg::ACCESS_CYC;

   // All checks below watch the one command clock and sleep during reset.
   default clocking cb_main @(posedge clk_i);
   endclocking

   default disable iff (!arst_n_i);

   function automatic logic [BW-1:0] beat_low(
      input logic [BW-1:0] start,
      input logic [BW-1:0] count,
      input logic          interleave
   );
      return interleave ? (start ^ count) : BW'(start + count);
   endfunction

   function automatic logic [DW-1:0] merge_lanes(
      input logic [DW-1:0] old_word,
      input logic [DW-1:0] new_word,
      input logic [NL-1:0] lanes
   );
      logic [DW-1:0] res;
      res = old_word;
      for (int i = 0; i < NL; i++) begin
         if (lanes[i]) begin
            res[i*LW +: LW] = new_word[i*LW +: LW];
         end
      end
      return res;
   endfunction

   logic                 qual;
   logic                 selected;
   logic                 load_cmd;
   ftbs_pkg::ftbs_slot_e slot_q;
   logic [AW-1:0]        base_q;
   logic [BW-1:0]        count_q;
   logic [NL-1:0]        lanes_q;
   logic                 strap_taken_q;
   logic                 interleave_q;
   logic [AW-1:0]        beat_addr;
   ftbs_pkg::ftbs_wr_s   post_in;
   ftbs_pkg::ftbs_wr_s   post_head;
   logic [ftbs_pkg::WR_W-1:0] post_head_raw;
   logic                 post_valid;
   logic                 post_push;
   logic [DW-1:0]        mem_q [0:(1 << ARRAY_AW)-1];
   logic [DW-1:0]        array_word;
   logic                 test_clk_q;
   logic                 test_rise;
   logic                 test_fall;
   logic                 test_mode_q;
   logic                 test_cap_q;
   logic                 test_out_q;

   assign qual     = ~clock_qualifier_n_i;
   assign selected = ~chip_select_first_n_i & chip_select_second_i &
                     ~chip_select_third_n_i;
   assign load_cmd = qual & ~advance_or_load_i;

   // The strap is caught once after reset, so it never feeds the reset path.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap_taken_q <= 1'b0;
         interleave_q  <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_taken_q <= 1'b1;
         interleave_q  <= burst_order_strap_i;
      end
   end

   // Every command slot is taken without wait states, read or not.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         slot_q <= ftbs_pkg::SLOT_IDLE;
      end else if (load_cmd) begin
         if (!selected) begin
            slot_q <= ftbs_pkg::SLOT_IDLE;
         end else if (write_n_i) begin
            slot_q <= ftbs_pkg::SLOT_READ;
         end else begin
            slot_q <= ftbs_pkg::SLOT_WRITE;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         base_q <= '0;
      end else if (load_cmd && selected) begin
         base_q <= addr_i;
      end
   end

   // Advance ignores selects and write select, so the type stays as loaded.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_q <= ftbs_pkg::BURST_FIRST;
      end else if (qual) begin
         if (!advance_or_load_i) begin
            count_q <= ftbs_pkg::BURST_FIRST;
         end else begin
            count_q <= count_q + ftbs_pkg::BURST_STEP;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lanes_q <= '0;
      end else if (qual) begin
         lanes_q <= ~byte_lane_write_n_i;
      end
   end

   assign beat_addr = {base_q[AW-1:BW],
                       beat_low(base_q[BW-1:0], count_q, interleave_q)};

   // Write data enters the posting FIFO at the edge after its command.
   assign post_push     = qual & (slot_q == ftbs_pkg::SLOT_WRITE);
   assign post_in.addr  = beat_addr;
   assign post_in.data  = data_i;
   assign post_in.lanes = lanes_q;
   assign post_head     = ftbs_pkg::ftbs_wr_s'(post_head_raw);

   // Draining stops while suspended so no state moves under the qualifier.
   ftbs_fifo #(
      .WIDTH (ftbs_pkg::WR_W),
      .DEPTH (ftbs_pkg::FIFO_DEPTH)
   ) u_post (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (post_push),
      .in_ready_o  (post_ready_o),
      .in_data_i   (post_in),
      .out_valid_o (post_valid),
      .out_ready_i (qual),
      .out_data_o  (post_head_raw)
   );

   always_ff @(posedge clk_i) begin
      if (post_valid && qual) begin
         mem_q[ARRAY_AW'(post_head.addr)] <=
            merge_lanes(mem_q[ARRAY_AW'(post_head.addr)],
                        post_head.data, post_head.lanes);
      end
   end

   // A write still waiting in the FIFO is merged in, so reads never see
   // stale bytes of a word written just before.
   assign array_word = mem_q[ARRAY_AW'(beat_addr)];
   always_comb begin
      if (post_valid &&
          (ARRAY_AW'(post_head.addr) == ARRAY_AW'(beat_addr))) begin
         data_o = merge_lanes(array_word, post_head.data, post_head.lanes);
      end else begin
         data_o = array_word;
      end
   end

   // Output enable only counts in a read slot.
   assign data_oe_o = (slot_q == ftbs_pkg::SLOT_READ) &
                      ~output_enable_n_i;

   // The test clock is an ordinary synchronous input; edges are found here.
   assign test_rise = test_clk_i & ~test_clk_q;
   assign test_fall = ~test_clk_i & test_clk_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         test_clk_q  <= 1'b0;
         test_mode_q <= 1'b1;
         test_cap_q  <= 1'b0;
         test_out_q  <= 1'b0;
      end else begin
         test_clk_q <= test_clk_i;
         if (test_rise) begin
            test_mode_q <= test_mode_i;
            test_cap_q  <= test_data_i;
         end
         if (test_fall) begin
            test_out_q <= test_cap_q;
         end
      end
   end

   assign test_data_o    = test_out_q;
   assign test_data_oe_o = ~test_mode_q;

   sequence s_load_sel;
      qual && !advance_or_load_i && selected;
   endsequence

   sequence s_read_start;
      s_load_sel and write_n_i;
   endsequence

   sequence s_write_start;
      s_load_sel ##0 !write_n_i;
   endsequence

   chk_load_addr: assert property (
      s_load_sel |=> base_q == $past(addr_i) && count_q == '0)
      else $error("Loaded address not latched.");

   chk_start_type: assert property (
      s_load_sel |=>
         (slot_q == ftbs_pkg::SLOT_WRITE) == !$past(write_n_i))
      else $error("Access type does not follow write select.");

   chk_suspend_hold: assert property (
      clock_qualifier_n_i |=> $stable(slot_q) && $stable(count_q) &&
                              $stable(base_q) && $stable(lanes_q))
      else $error("State moved while suspended.");

   chk_read_drive: assert property (
      s_read_start ##1 !output_enable_n_i |-> ##[0:ACCESS_CYC] data_oe_o)
      else $error("Read data not driven in flow-through cycle.");

   chk_desel_off: assert property (
      qual && !advance_or_load_i && !selected |=> !data_oe_o)
      else $error("Outputs driven after deselect.");

   chk_write_off: assert property (
      slot_q != ftbs_pkg::SLOT_READ |-> !data_oe_o)
      else $error("Outputs driven outside a read slot.");

   chk_write_beat: assert property (
      s_write_start |=> !data_oe_o)
      else $error("Outputs driven during a write data beat.");

   chk_burst_step: assert property (
      qual && advance_or_load_i |=>
         count_q == BW'($past(count_q) + 1'b1) && $stable(slot_q))
      else $error("Burst did not advance with held type.");

   chk_burst_load: assert property (
      qual && !advance_or_load_i |=> count_q == ftbs_pkg::BURST_FIRST)
      else $error("Burst count not restarted on load.");

   // Checked backwards from the beat address, so it is not a copy of the
   // forward formula.
   chk_beat_order: assert property (
      beat_addr[AW-1:BW] == base_q[AW-1:BW] &&
      (interleave_q ? (beat_addr[BW-1:0] ^ base_q[BW-1:0]) :
                      BW'(beat_addr[BW-1:0] - base_q[BW-1:0])) == count_q)
      else $error("Beat address order wrong.");

   chk_lane_take: assert property (
      qual |=> lanes_q == ~$past(byte_lane_write_n_i))
      else $error("Byte lane strobes not captured.");

   chk_write_post: assert property (
      s_write_start ##1 qual |-> post_push)
      else $error("Write data not taken on the following edge.");

   chk_post_room: assert property (
      qual && slot_q == ftbs_pkg::SLOT_WRITE |-> post_ready_o)
      else $error("Write beat met a full posting buffer.");

   chk_scan_shift: assert property (
      test_fall |=> test_data_o == $past(test_cap_q))
      else $error("Scan output not shifted on falling test clock.");

   chk_scan_sample: assert property (
      test_rise |=> test_cap_q == $past(test_data_i))
      else $error("Scan input not sampled on rising test clock.");

   chk_scan_mode: assert property (
      test_rise |=> test_data_oe_o == !$past(test_mode_i))
      else $error("Scan mode not sampled on rising test clock.");

endmodule
`default_nettype wire

// File: logic/ftbs_pkg.sv
// Shared constants and carrier types of the flow-through burst SRAM access.
package ftbs_pkg;

   localparam int ADDR_W     = 19;
   localparam int LANES      = 4;
   localparam int LANE_W     = 9;
   localparam int DATA_W     = LANES * LANE_W;
   localparam int BURST_W    = 2;
   localparam int FIFO_DEPTH = 8;

   // Clock-to-data figures in picoseconds; the access time rounds down, but never below one cycle.
   localparam int CLK_PERIOD_PS = 10000;
   localparam int T_ACCESS_PS   = 6500;
   localparam int ACCESS_CYC    = (T_ACCESS_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                  (T_ACCESS_PS / CLK_PERIOD_PS);

   localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

   typedef enum logic [1:0] {
      SLOT_IDLE,
      SLOT_READ,
      SLOT_WRITE
   } ftbs_slot_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  lanes;
   } ftbs_wr_s;

   localparam int WR_W = $bits(ftbs_wr_s);

endpackage

// File: logic/ftbs_fifo.sv
// Write-posting FIFO between the data input and the array.
`timescale 1ns/1ps
`default_nettype none
module ftbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_q [0:DEPTH-1];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [PW:0]      fill_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (fill_q != (PW+1)'(DEPTH));
   assign out_valid_o = (fill_q != '0);
   assign out_data_o  = store_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         store_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q   <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule
`default_nettype wire

// File: sim/ftbs_ctrl_model.sv
// Memory controller model driving the command side of the SRAM block.
`timescale 1ns/1ps
`default_nettype none
module ftbs_ctrl_model (
   output logic        qual_n_o,
   output logic        cs1_n_o,
   output logic        cs2_o,
   output logic        cs3_n_o,
   output logic        adv_o,
   output logic        write_n_o,
   output logic [3:0]  lanes_n_o,
   output logic [18:0] addr_o,
   output logic        oe_n_o,
   output logic [35:0] data_o
);
   logic [1:0] rot = 2'h0;
   logic       desel_q = 1'h1;

   initial begin
      {qual_n_o, cs1_n_o, cs2_o, cs3_n_o, adv_o, write_n_o} = 6'h3F;
      lanes_n_o = 4'hF;
      addr_o = 19'h0;
      oe_n_o = 1'h0;
      data_o = 36'h0;
   end

   // Each deselect drops a different select pin, so all three get tried.
   task automatic issue(input logic qn, sel, adv, wn, input logic [3:0] ln,
                        input logic [18:0] a, input logic oen, wb,
                        input logic [35:0] wd);
      qual_n_o = qn;
      cs1_n_o = !sel && rot == 2'h0;
      cs2_o = sel || rot != 2'h1;
      cs3_n_o = !sel && rot == 2'h2;
      adv_o = adv && !desel_q;
      write_n_o = wn;
      lanes_n_o = ln;
      addr_o = a;
      oe_n_o = oen;
      // Released lines flip rather than hold, so stale data cannot pass.
      data_o = wb ? wd : ~data_o;
      if (!qn) begin
         desel_q = !adv_o && !sel;
         if (!sel) rot = rot == 2'h2 ? 2'h0 : rot + 2'h1;
      end
   endtask
endmodule
`default_nettype wire

// File: sim/tb_flow_through_burst_sram_access.sv
// Self-checking bench of the flow-through burst SRAM access block.
`timescale 1ns/1ps
`default_nettype none
module tb_flow_through_burst_sram_access;
   typedef struct packed {
      logic        rd;
      logic [35:0] d;
   } ftbs_exp_s;
   logic        clk_i = 1'h0;
   logic        arst_n_i = 1'h0;
   logic        strap = 1'h0;
   logic        tck = 1'h0;
   logic        tdi = 1'h0;
   logic        tms = 1'h0;
   logic        qn, c1, c2, c3, adv, wn, oen, oe, tdo, tdo_oe, rdy;
   logic [3:0]  ln;
   logic [18:0] a;
   logic [35:0] wd, rdata;
   logic [35:0] mem [64];
   logic [5:0]  ba, pa;
   logic [3:0]  pl;
   logic [1:0]  cnt;
   logic        live, wr, pv, oe_n;
   logic [31:0] rng = 32'h00009DB8;
   ftbs_exp_s   q[$];
   ftbs_exp_s   e, m;
   int          mismatches = 0;
   int          tests_run = 0;

   always #5 clk_i = ~clk_i;

   ftbs_ctrl_model ctrl (.qual_n_o(qn), .cs1_n_o(c1), .cs2_o(c2),
      .cs3_n_o(c3), .adv_o(adv), .write_n_o(wn), .lanes_n_o(ln),
      .addr_o(a), .oe_n_o(oen), .data_o(wd));

   ftbs_access #(.ARRAY_AW(6)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .clock_qualifier_n_i(qn), .chip_select_first_n_i(c1),
      .chip_select_second_i(c2), .chip_select_third_n_i(c3),
      .advance_or_load_i(adv), .write_n_i(wn), .byte_lane_write_n_i(ln),
      .addr_i(a), .output_enable_n_i(oen), .burst_order_strap_i(strap),
      .data_i(wd), .data_o(rdata), .data_oe_o(oe), .post_ready_o(rdy),
      .test_clk_i(tck), .test_data_i(tdi), .test_mode_i(tms),
      .test_data_o(tdo), .test_data_oe_o(tdo_oe));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic check(input logic [35:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (mismatches == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One bus cycle: drive just after the edge, note what the next
   // cycle must show once the edge has been taken.
   task automatic cyc(input logic sq, sel, ad, w_n, input logic [3:0] l,
                      input logic [5:0] ad_a);
      logic [5:0]  b;
      logic [35:0] w;
      rng = xs(rng);
      w = {rng[3:0], rng};
      #1 ctrl.issue(sq, sel, ad, w_n, l, {13'h0, ad_a}, oe_n, pv, w);
      if (!sq) begin
         for (int i = 0; i < 4; i++)
            if (pv && !pl[i]) mem[pa][9*i+:9] = w[9*i+:9];
         if (!ad) begin
            live = sel;
            wr = !w_n;
            ba = ad_a;
            cnt = 2'h0;
         end else if (live) begin
            cnt = cnt + 2'h1;
         end
         b = {ba[5:2], strap ? ba[1:0] ^ cnt : ba[1:0] + cnt};
         pv = live && wr;
         pa = b;
         pl = l;
         e = '{live && !wr, mem[b]};
      end
      @(posedge clk_i);
      q.push_back(e);
   endtask

   task automatic ld(input logic w_n, input logic [3:0] l,
                     input logic [5:0] ad_a);
      cyc(1'h0, 1'h1, 1'h0, w_n, l, ad_a);
   endtask

   // Selects, write select and address are random on purpose here.
   task automatic nx(input logic sq);
      cyc(sq, rng[1], 1'h1, rng[2], rng[3:0], rng[9:4]);
   endtask

   task automatic ds();
      cyc(1'h0, 1'h0, 1'h0, 1'h1, 4'hF, 6'h0);
   endtask

   task automatic rst(input logic s);
      #1 arst_n_i = 1'h0;
      strap = s;
      live = 1'h0;
      pv = 1'h0;
      oe_n = 1'h0;
      repeat (2) @(posedge clk_i);
      #1 arst_n_i = 1'h1;
      @(posedge clk_i);
   endtask

   always @(negedge clk_i) begin
      if (q.size() > 0) begin
         m = q.pop_front();
         check({35'h0, oe}, {35'h0, m.rd && !oen});
         check({35'h0, rdy}, 36'h1);
         if (m.rd && !oen) check(rdata, m.d);
      end
   end

   initial begin
      for (int s = 0; s < 2; s++) begin
         rst(s[0]);
         // Back-to-back writes, then a patched word read at once.
         for (int k = 0; k < 4; k++) ld(1'h0, 4'h0, 6'h10 + k[5:0]);
         ld(1'h0, 4'h0, 6'h20);
         ld(1'h0, 4'h5, 6'h20);
         ld(1'h1, 4'hF, 6'h20);
         // Bursts from every start; one edge suspended, fifth beat wraps.
         for (int st = 0; st < 4; st++) begin
            ld(1'h1, 4'hF, 6'h10 + st[5:0]);
            for (int k = 0; k < 5; k++) begin
               oe_n = k == 3;
               nx(k == 1);
            end
            oe_n = 1'h0;
            ds();
         end
         // Later beats carry a random write select, which must not turn the burst round.
         ld(1'h0, rng[3:0], 6'h12);
         repeat (3) nx(1'h0);
         ld(1'h1, 4'hF, 6'h12);
         repeat (4) nx(1'h0);
         ds();
      end
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_i);
         #1 tdi = !v[0];
         tms = v[0];
         repeat (3) @(posedge clk_i);
         #1 tck = 1'h1;
         repeat (3) @(posedge clk_i);
         #1 tck = 1'h0;
         repeat (3) @(posedge clk_i);
         #1 check({34'h0, tdo, tdo_oe}, {34'h0, !v[0], !v[0]});
      end
      complete_run();
   end

   initial begin
      #20us;
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
